// ===== hw/event_channel_mux.sv
// Event channel selector; out-of-range selections yield a constant low
`timescale 1ns/100ps
module event_channel_mux #(
	parameter int CHANNELS = 12
) (
	input wire logic [CHANNELS-1:0] channels,
	input wire logic [3:0] select,
	output logic picked
);
	always_comb begin
		picked = 1'b0;
		if (int'(select) < CHANNELS) begin
			picked = channels[select];
		end
	end
endmodule

// ===== hw/infrared_codec.sv
// Infrared pulse modulator and filtered demodulator
`timescale 1ns/100ps
module infrared_codec (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic bit_tick,
	input wire logic [1:0] pulse_width,
	input wire logic ovs_eighth,
	input wire logic filter_on,
	input wire logic mod_in,
	input wire logic ir_rx,
	output logic ir_tx,
	output logic rx_recovered
);
	logic [3:0] phase;
	logic [2:0] high_run;
	logic prev_in;
	logic [3:0] limit;

	// Length of one bit in sub-period units; 16 units at 1/16, 8 at 1/8
	always_comb begin
		limit = ovs_eighth ? 4'h7 : 4'hf;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 4'h0;
			prev_in <= 1'b1;
			ir_tx <= 1'b0;
		end else if (ce && bit_tick) begin
			prev_in <= mod_in;
			// A zero bit is sent as a short high pulse at the bit start
			if (phase == limit || (prev_in != mod_in)) begin
				phase <= 4'h0;
				ir_tx <= !mod_in;
			end else begin
				phase <= phase + 4'h1;
				if ({2'b00, pulse_width} == phase) begin
					ir_tx <= 1'b0;
				end
			end
		end
	end

	// Received pulses are active high; the line reads low while a pulse is seen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_run <= 3'h0;
			rx_recovered <= 1'b1;
		end else if (ce) begin
			if (!ir_rx) begin
				high_run <= 3'h0;
				rx_recovered <= 1'b1;
			end else begin
				if (high_run != 3'h7) begin
					high_run <= high_run + 3'h1;
				end
				if (!filter_on || int'(high_run) >= serial_irq_pkg::FILTER_CYCLES - 1) begin
					rx_recovered <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== hw/serial_irq_pkg.sv
// Constants shared by the serial port interrupt, infrared and input routing block
package serial_irq_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_FLAGS = 17;
	localparam int NUM_CHANNELS = 12;
	localparam int SEL_W = 4;
	localparam logic [7:0] OFS_FLAG_SET = 8'h44;
	localparam logic [7:0] OFS_FLAG_CLEAR = 8'h48;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h4c;
	localparam logic [7:0] OFS_INFRARED_CONTROL = 8'h50;
	localparam logic [7:0] OFS_INPUT_ROUTING = 8'h58;
	localparam logic [7:0] OFS_MISC_CONTROL = 8'h70;
	// Flags with no software clear or set: rx data valid (bit 2) and tx level (bit 1)
	localparam logic [16:0] CLEARABLE_MASK = 17'h1fff9;
	localparam logic [16:0] IRQ_ENABLE_RESET = 17'h00000;
	localparam logic [16:0] FLAG_RESET = 17'h00000;
	localparam logic [11:0] INFRARED_CONTROL_MASK = 12'hf8f;
	localparam logic [15:0] INPUT_ROUTING_MASK = 16'h8f8f;
	localparam int IR_ENABLE_BIT = 0;
	localparam int IR_PW_LSB = 1;
	localparam int IR_FILTER_BIT = 3;
	localparam int IR_CH_ENABLE_BIT = 7;
	localparam int IR_CH_SEL_LSB = 8;
	localparam int RX_SEL_LSB = 0;
	localparam int RX_EV_ENABLE_BIT = 7;
	localparam int CLK_SEL_LSB = 8;
	localparam int CLK_EV_ENABLE_BIT = 15;
	localparam int READ_CLEAR_BIT = 0;
	localparam int OVS_BIT = 1;
	localparam int FILTER_CYCLES = 4;
	localparam int PULSE_W_UNITS = 16;
endpackage

// ===== hw/serial_irq_regs.sv
// Interrupt flag, enable, infrared control and input routing registers
`timescale 1ns/100ps
// Functional notes
// - Writing one to a clear bit clears that flag; zeros leave flags alone.
// - With read-clear enabled, reading the clear register returns and clears flags.
// - Clear bits exist at 16..3 and 0; bits 2:1 are reserved.
// - Enable register holds seventeen read/write bits, all reset to zero.
// - Enables exist for rx data valid and tx level flags too.
// - Infrared channel select picks event channel 0 to 11.
// - With filter on, a received pulse must stay high four cycles.
// - Pulse width n gives (n+1)/16 or (n+1)/8 of a bit.
// - Clock event enable takes the serial clock from the selected channel.
// - Clock channel select chooses channel 0 to 11, reset to 0.
// - Receive event enable takes serial input from the selected channel.
// - Receive channel select chooses channel 0 to 11.
// - Writing one to a set register bit sets that flag.
module serial_irq_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [16:0] flag_events,
	input wire logic rx_data_valid_flag,
	input wire logic tx_level_flag,
	input wire logic [11:0] event_channels,
	input wire logic tx_data,
	input wire logic bit_tick,
	input wire logic rx_pin,
	input wire logic clk_pin,
	input wire logic ir_rx_pin,
	output logic irq,
	output logic tx_out,
	output logic rx_serial,
	output logic serial_clk
);
	logic [16:0] flags;
	logic [16:0] irq_enable_bits;
	logic [11:0] infrared_control;
	logic [15:0] input_routing;
	logic [1:0] misc_control;
	logic [16:0] flag_vector;
	logic [16:0] next_flags;
	logic rx_s1, rx_s2, clk_s1, clk_s2, ir_s1, ir_s2;
	logic ir_source, rx_source, clk_source;
	logic ir_tx, ir_rx_line, mod_in;
	logic wr_clear, wr_set, rd_clear;

	assign wr_clear = wr && addr == serial_irq_pkg::OFS_FLAG_CLEAR;
	assign wr_set = wr && addr == serial_irq_pkg::OFS_FLAG_SET;
	assign rd_clear = rd && addr == serial_irq_pkg::OFS_FLAG_CLEAR && misc_control[serial_irq_pkg::READ_CLEAR_BIT];

	// Hardware-driven level flags are merged into the visible vector
	always_comb begin
		flag_vector = flags;
		flag_vector[2] = rx_data_valid_flag;
		flag_vector[1] = tx_level_flag;
	end

	// Clears apply first, then hardware events and software sets win
	always_comb begin
		next_flags = flags;
		if (wr_clear) begin
			next_flags = next_flags & ~(wdata[16:0] & serial_irq_pkg::CLEARABLE_MASK);
		end
		if (rd_clear) begin
			next_flags = next_flags & ~serial_irq_pkg::CLEARABLE_MASK;
		end
		next_flags = next_flags | (flag_events & serial_irq_pkg::CLEARABLE_MASK);
		if (wr_set) begin
			next_flags = next_flags | (wdata[16:0] & serial_irq_pkg::CLEARABLE_MASK);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= serial_irq_pkg::FLAG_RESET;
		end else if (ce) begin
			flags <= next_flags;
		end
	end

	// Reserved bits are simply not stored, so stray writes there are harmless
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_bits <= serial_irq_pkg::IRQ_ENABLE_RESET;
			infrared_control <= 12'h000;
			input_routing <= 16'h0000;
			misc_control <= 2'h0;
		end else if (ce && wr) begin
			case (addr)
				serial_irq_pkg::OFS_IRQ_ENABLE: begin
					irq_enable_bits <= wdata[16:0];
				end
				serial_irq_pkg::OFS_INFRARED_CONTROL: begin
					infrared_control <= wdata[11:0] & serial_irq_pkg::INFRARED_CONTROL_MASK;
				end
				serial_irq_pkg::OFS_INPUT_ROUTING: begin
					input_routing <= wdata[15:0] & serial_irq_pkg::INPUT_ROUTING_MASK;
				end
				serial_irq_pkg::OFS_MISC_CONTROL: begin
					misc_control <= wdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h00000000;
		end else if (ce) begin
			rdata <= 32'h00000000;
			if (rd) begin
				case (addr)
					serial_irq_pkg::OFS_FLAG_CLEAR: begin
						if (misc_control[serial_irq_pkg::READ_CLEAR_BIT]) begin
							rdata <= {15'h0000, flag_vector};
						end
					end
					serial_irq_pkg::OFS_IRQ_ENABLE: rdata <= {15'h0000, irq_enable_bits};
					serial_irq_pkg::OFS_INFRARED_CONTROL: rdata <= {20'h00000, infrared_control};
					serial_irq_pkg::OFS_INPUT_ROUTING: rdata <= {16'h0000, input_routing};
					serial_irq_pkg::OFS_MISC_CONTROL: rdata <= {30'h00000000, misc_control};
					default: rdata <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(flag_vector & irq_enable_bits);
		end
	end

	// Pin inputs come from outside the clock domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Reset to each pin's idle level so no false edge follows reset
			{rx_s1, rx_s2} <= 2'h3;
			{clk_s1, clk_s2, ir_s1, ir_s2} <= 4'h0;
		end else if (ce) begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
			clk_s1 <= clk_pin;
			clk_s2 <= clk_s1;
			ir_s1 <= ir_rx_pin;
			ir_s2 <= ir_s1;
		end
	end

	event_channel_mux #(.CHANNELS(serial_irq_pkg::NUM_CHANNELS)) ir_mux (
		.channels(event_channels),
		.select(infrared_control[serial_irq_pkg::IR_CH_SEL_LSB +: 4]),
		.picked(ir_source)
	);
	event_channel_mux #(.CHANNELS(serial_irq_pkg::NUM_CHANNELS)) rx_mux (
		.channels(event_channels),
		.select(input_routing[serial_irq_pkg::RX_SEL_LSB +: 4]),
		.picked(rx_source)
	);
	event_channel_mux #(.CHANNELS(serial_irq_pkg::NUM_CHANNELS)) clk_mux (
		.channels(event_channels),
		.select(input_routing[serial_irq_pkg::CLK_SEL_LSB +: 4]),
		.picked(clk_source)
	);

	assign mod_in = infrared_control[serial_irq_pkg::IR_CH_ENABLE_BIT] ? ir_source : tx_data;

	infrared_codec codec (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.bit_tick(bit_tick),
		.pulse_width(infrared_control[serial_irq_pkg::IR_PW_LSB +: 2]),
		.ovs_eighth(misc_control[serial_irq_pkg::OVS_BIT]),
		.filter_on(infrared_control[serial_irq_pkg::IR_FILTER_BIT]),
		.mod_in(mod_in),
		.ir_rx(ir_s2),
		.ir_tx(ir_tx),
		.rx_recovered(ir_rx_line)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_out <= 1'b1;
			rx_serial <= 1'b1;
			serial_clk <= 1'b0;
		end else if (ce) begin
			if (infrared_control[serial_irq_pkg::IR_ENABLE_BIT]) begin
				tx_out <= ir_tx;
			end else begin
				tx_out <= mod_in;
			end
			if (input_routing[serial_irq_pkg::RX_EV_ENABLE_BIT]) begin
				rx_serial <= rx_source;
			end else if (infrared_control[serial_irq_pkg::IR_ENABLE_BIT]) begin
				rx_serial <= ir_rx_line;
			end else begin
				rx_serial <= rx_s2;
			end
			serial_clk <= input_routing[serial_irq_pkg::CLK_EV_ENABLE_BIT] ? clk_source : clk_s2;
		end
	end

	property p_clear_write;
		@(posedge clk) disable iff (!rst_n)
		(ce && wr_clear && wdata[0] && !flag_events[0] && !wr_set) |=> !flags[0];
	endproperty
	a_clear_write: assert property (p_clear_write) else $error("clear write left flag set");
	property p_clear_zero;
		@(posedge clk) disable iff (!rst_n)
		(ce && wr_clear && !wdata[5] && !rd_clear && flags[5]) |=> flags[5];
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("zero clear bit changed flag");
	property p_read_clear;
		@(posedge clk) disable iff (!rst_n)
		(ce && rd_clear && !wr && flag_events == 17'h00000) |=> (flags == 17'h00000 && rdata[16:0] == $past(flag_vector));
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read clear wrong");
	property p_reserved;
		@(posedge clk) disable iff (!rst_n)
		flags[2:1] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved flag bits stored");
	property p_enable_rw;
		@(posedge clk) disable iff (!rst_n)
		(ce && wr && addr == serial_irq_pkg::OFS_IRQ_ENABLE) |=> irq_enable_bits == $past(wdata[16:0]);
	endproperty
	a_enable_rw: assert property (p_enable_rw) else $error("enable write lost");
	property p_set;
		@(posedge clk) disable iff (!rst_n)
		(ce && wr_set && wdata[9]) |=> flags[9];
	endproperty
	a_set: assert property (p_set) else $error("set write ignored");
	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		ce |=> irq == |($past(flag_vector) & $past(irq_enable_bits));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	property p_clk_route;
		@(posedge clk) disable iff (!rst_n)
		(ce && input_routing[15] && input_routing[11:8] >= 4'hc) |=> !serial_clk;
	endproperty
	a_clk_route: assert property (p_clk_route) else $error("bad channel not low");
	property p_rx_route;
		@(posedge clk) disable iff (!rst_n)
		(ce && input_routing[7]) |=> rx_serial == $past(rx_source);
	endproperty
	a_rx_route: assert property (p_rx_route) else $error("rx route wrong");
	property p_enable_read;
		@(posedge clk) disable iff (!rst_n)
		(ce && rd && addr == serial_irq_pkg::OFS_IRQ_ENABLE) |=> rdata == {15'h0000, $past(irq_enable_bits)};
	endproperty
	a_enable_read: assert property (p_enable_read) else $error("enable read wrong");
	property p_ir_rx_route;
		@(posedge clk) disable iff (!rst_n)
		(ce && infrared_control[0] && !input_routing[7]) |=> rx_serial == $past(ir_rx_line);
	endproperty
	a_ir_rx_route: assert property (p_ir_rx_route) else $error("infrared rx path wrong");
	property p_tx_bypass;
		@(posedge clk) disable iff (!rst_n)
		(ce && !infrared_control[0]) |=> tx_out == $past(mod_in);
	endproperty
	a_tx_bypass: assert property (p_tx_bypass) else $error("tx bypass wrong");
	property p_tx_channel;
		@(posedge clk) disable iff (!rst_n)
		(ce && infrared_control[7] && !infrared_control[0]) |=> tx_out == $past(ir_source);
	endproperty
	a_tx_channel: assert property (p_tx_channel) else $error("tx channel source wrong");
	property p_clk_pin;
		@(posedge clk) disable iff (!rst_n)
		(ce && !input_routing[15]) |=> serial_clk == $past(clk_s2);
	endproperty
	a_clk_pin: assert property (p_clk_pin) else $error("clock pin path wrong");
	property p_rx_bad_sel;
		@(posedge clk) disable iff (!rst_n)
		(ce && input_routing[7] && input_routing[3:0] >= 4'hc) |=> !rx_serial;
	endproperty
	a_rx_bad_sel: assert property (p_rx_bad_sel) else $error("bad rx channel not low");
	property p_flag_hold;
		@(posedge clk) disable iff (!rst_n)
		(ce && !wr && !rd && flag_events == 17'h00000) |=> flags == $past(flags);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flags changed without cause");
	property p_irq_off;
		@(posedge clk) disable iff (!rst_n)
		(ce && (flag_vector & irq_enable_bits) == 17'h00000) |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq high with nothing enabled");
	c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
	c_read_clear: cover property (@(posedge clk) disable iff (!rst_n) rd_clear && flags != 17'h00000);
	c_ir_on: cover property (@(posedge clk) disable iff (!rst_n) infrared_control[0] && $rose(tx_out));
	c_filter: cover property (@(posedge clk) disable iff (!rst_n) infrared_control[3] && !ir_rx_line);
endmodule

// ===== tb/event_net_model.sv
// Event channel network model feeding the block's event inputs
`timescale 1ns/100ps
module event_net_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic on,
	input wire logic [3:0] sel,
	output logic [11:0] event_channels
);
	// One hot channel exposes a wrong pick; an out-of-range pick lights all, so a leak shows
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			event_channels <= 12'h000;
		else if (!on)
			event_channels <= 12'h000;
		else if (sel < 4'hc)
			event_channels <= 12'h001 << sel;
		else
			event_channels <= 12'hfff;
	end
endmodule

// ===== tb/serial_irq_regs_test.sv
// Bench for the serial interrupt, infrared and input routing registers
`timescale 1ns/100ps
module serial_irq_regs_test;
	logic clk, rst_n, ce, wr, rd, tx_data, bit_tick, rx_pin, clk_pin, ir_rx_pin, rxv, txl;
	logic irq, tx_out, rx_serial, serial_clk, ev_on;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic [16:0] flag_events;
	logic [11:0] event_channels;
	logic [3:0] ev_sel;
	int error_cnt, n_checks, lows, highs;

	serial_irq_regs i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .flag_events(flag_events), .rx_data_valid_flag(rxv), .tx_level_flag(txl),
		.event_channels(event_channels), .tx_data(tx_data), .bit_tick(bit_tick), .rx_pin(rx_pin),
		.clk_pin(clk_pin), .ir_rx_pin(ir_rx_pin), .irq(irq), .tx_out(tx_out), .rx_serial(rx_serial),
		.serial_clk(serial_clk));
	event_net_model i_net (.clk(clk), .rst_n(rst_n), .on(ev_on), .sel(ev_sel), .event_channels(event_channels));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Bus accesses start on an edge and return just after one, so strobes never clash
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rv, e);
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task pulse(input int n);
		lows = 0;
		for (int i = 0; i < n + 8; i++) begin
			@(posedge clk);
			ir_rx_pin <= (i < n);
			#1;
			if (rx_serial === 1'b0)
				lows++;
		end
	endtask

	// A data edge realigns the modulator, so counting starts at a known phase
	task txp(input int n);
		@(posedge clk) tx_data <= 1'b0;
		highs = 0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			if (tx_out === 1'b1)
				highs++;
		end
		@(posedge clk) tx_data <= 1'b1;
	endtask

	task conclude;
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		conclude();
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		flag_events = 17'h0;
		rxv = 1'b0;
		txl = 1'b0;
		tx_data = 1'b1;
		bit_tick = 1'b0;
		rx_pin = 1'b1;
		clk_pin = 1'b0;
		ir_rx_pin = 1'b0;
		ev_on = 1'b0;
		ev_sel = 4'h0;
		error_cnt = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(8'h4c, 32'h0);
		rdc(8'h50, 32'h0);
		rdc(8'h58, 32'h0);
		chk(irq, 1'b0);
		chk(tx_out, 1'b1);
		acc(1'b1, 8'h4c, 32'h1ffff);
		rdc(8'h4c, 32'h1ffff);
		acc(1'b1, 8'h50, 32'hf8f);
		rdc(8'h50, 32'hf8f);
		acc(1'b1, 8'h58, 32'h8f8f);
		rdc(8'h58, 32'h8f8f);
		rdc(8'h60, 32'h0);
		rdc(8'h48, 32'h0);
		// Flags first set through the set register, then cleared by a read
		acc(1'b1, 8'h44, 32'h1fff9);
		cyc(1);
		chk(irq, 1'b1);
		acc(1'b1, 8'h70, 32'h1);
		rdc(8'h48, 32'h1fff9);
		cyc(1);
		chk(irq, 1'b0);
		acc(1'b1, 8'h44, 32'h1fff9);
		acc(1'b1, 8'h48, 32'h8);
		rdc(8'h48, 32'h1fff1);
		@(posedge clk) flag_events <= 17'h00200;
		@(posedge clk) flag_events <= 17'h0;
		cyc(1);
		rdc(8'h48, 32'h200);
		// Receive-valid has no clear bit, so a write of every clear bit must leave irq up
		@(posedge clk) rxv <= 1'b1;
		acc(1'b1, 8'h4c, 32'h4);
		acc(1'b1, 8'h48, 32'h1fff9);
		cyc(2);
		chk(irq, 1'b1);
		acc(1'b1, 8'h4c, 32'h1);
		cyc(1);
		chk(irq, 1'b0);
		@(posedge clk) rxv <= 1'b0;
		@(posedge clk) ev_on <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			acc(1'b1, 8'h58, 32'h8080 | (k << 8) | k);
			@(posedge clk) ev_sel <= k[3:0];
			cyc(4);
			chk(rx_serial, k < 12);
			chk(serial_clk, k < 12);
		end
		acc(1'b1, 8'h58, 32'h0);
		acc(1'b1, 8'h50, 32'h0);
		@(posedge clk) rx_pin <= 1'b0;
		cyc(4);
		chk(rx_serial, 1'b0);
		acc(1'b1, 8'h50, 32'h9);
		pulse(3);
		chk(lows, 0);
		pulse(6);
		chk(lows, 3);
		acc(1'b1, 8'h50, 32'h1);
		pulse(1);
		chk(lows, 1);
		acc(1'b1, 8'h50, 32'h5);
		@(posedge clk) bit_tick <= 1'b1;
		txp(32);
		chk(highs, 6);
		acc(1'b1, 8'h70, 32'h3);
		txp(16);
		chk(highs, 6);
		@(posedge clk) ev_sel <= 4'ha;
		acc(1'b1, 8'h50, 32'ha80);
		txp(16);
		chk(highs, 16);
		conclude();
	end
endmodule
